/* pkg/brre_pkg.sv */
// brre_pkg: constants and types for the bus record replay engine.
// assumes: 32-bit apb register bus, one clock (pclk, 25 mhz).
package brre_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] BRRE_REG_CTRL    = 8'h00; // enables and options
	localparam logic [7:0] BRRE_REG_COUNT   = 8'h04; // entry count / remaining
	localparam logic [7:0] BRRE_REG_HALFCNT = 8'h08; // half-buffer events
	localparam logic [7:0] BRRE_REG_SWXMASK = 8'h0C; // status exception mask
	localparam logic [7:0] BRRE_REG_STATUS  = 8'h10; // running, rejects
	localparam logic [7:0] BRRE_REG_WORD    = 8'h14; // current fetched word
	localparam logic [7:0] BRRE_REG_ERRDEC  = 8'h18; // decoded error entry
	localparam logic [7:0] BRRE_REG_TIMEOUT = 8'h1C; // response timeout count

	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int BRRE_CTRL_START  = 0;  // replay enable request
	localparam int BRRE_CTRL_HALFIE = 1;  // half-buffer interrupt enable
	localparam int BRRE_CTRL_TT_LO  = 2;  // time-tag mode, 2 bits
	localparam int BRRE_CTRL_RTDIS  = 4;  // suppress selected rt
	localparam int BRRE_CTRL_RTA_LO = 5;  // rt address, 5 bits

	// ----------------------------------------------------------------
	// monitor word layout
	// ----------------------------------------------------------------
	localparam logic [3:0] BRRE_TYPE_NOTUPD = 4'h0; // entry never updated
	localparam logic [3:0] BRRE_TYPE_ERROR  = 4'h1; // error-word entry
	localparam logic [3:0] BRRE_TYPE_TTLO   = 4'h2; // time tag low
	localparam logic [3:0] BRRE_TYPE_TTHI   = 4'h3; // time tag high
	localparam int BRRE_ERR_START = 26;  // start-trigger flag
	localparam int BRRE_ERR_TX    = 17;  // transmit command
	localparam int BRRE_ERR_RX    = 16;  // receive command
	localparam int BRRE_ERR_ANY   = 15;  // any-error summary

	// ----------------------------------------------------------------
	// sizes, resets, timing
	// ----------------------------------------------------------------
	localparam int          BRRE_BUF_BYTES   = 32'h20000;         // replay buffer bytes
	localparam int          BRRE_BUF_WORDS   = BRRE_BUF_BYTES / 4; // 32-bit words
	localparam logic [15:0] BRRE_SWX_RESET   = 16'h07FF;          // status bits 10..0 checked
	localparam int          BRRE_CLK_MHZ     = 25;
	localparam int          BRRE_TIMEOUT_US  = 14;                // no-response timeout
	localparam int          BRRE_TIMEOUT_CYC = BRRE_TIMEOUT_US * BRRE_CLK_MHZ;

	// time-tag replay options
	typedef enum logic [1:0] {
		BRRE_TT_FULL = 2'h0,
		BRRE_TT_LOW  = 2'h1,
		BRRE_TT_OFF  = 2'h2
	} brre_tt_t;

	// one memory read request and its address
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} brre_mreq_t;

	// one word for the protocol engine
	typedef struct packed {
		logic        valid;
		logic [3:0]  kind;
		logic [26:0] entry;
	} brre_txw_t;

endpackage : brre_pkg

/* design/brre_err_decode.sv */
// brre_err_decode: splits an error-word entry into its fields.
// assumes: combinational use by brre_top on the same clock.
`timescale 1ns/100ps
`default_nettype none
module brre_err_decode
	import brre_pkg::*;
(
	input  wire logic [31:0] word,      // monitor word
	output logic             is_error,  // type says error entry
	output logic             start_trg, // start-trigger flag
	output logic             tx_cmd,    // transmit command
	output logic             rx_cmd,    // receive command
	output logic [15:0]      err_field  // error bits with summary rebuilt
);
	// ----------------------------------------------------------------
	// field split
	// ----------------------------------------------------------------
	// bits 14..0 pass as recorded; bit 15 is recomputed so it never lies
	always_comb begin
		is_error  = (word[31:28] == BRRE_TYPE_ERROR);
		start_trg = word[BRRE_ERR_START];
		// rt-rt attribution is kept as recorded: the flag of the active rt is set
		tx_cmd    = word[BRRE_ERR_TX];
		rx_cmd    = word[BRRE_ERR_RX];
		err_field = {|word[14:0], word[14:0]};
	end
endmodule : brre_err_decode
`default_nettype wire

/* design/brre_top.sv */
// brre_top: replays recorded monitor words from a ring buffer onto the bus.
// assumes: apb slave; a shared-memory read port; a protocol engine that
// transmits words and reports the outside terminal's response.
//
// Overview of operation
// - error entry bit 26 marks start trigger
// - bit 17 transmit, bit 16 receive, 25:18 reserved
// - low sixteen bits hold error flags
// - bit 15 is or of 14..0
// - bits 14..8 protocol level faults
// - bits 7..0 word level faults
// - rt-rt errors go to active rt
// - status exception mask resets to 07FF
// - fetch recorded words and transmit them
// - buffer split into two equal halves
// - interrupt after each half transmitted
// - wrap to buffer start at end
// - stop at count or not-updated entry
// - selected rt suppressed, external answers tolerated
// - refuse replay while bc enabled
// - runs alongside rt and monitor
// - no error reproduction or handling
// - response timeout prevents lock-up
// - time-tag option and interrupt enable
// - readable half-buffer event counter
// - type zero means entry not updated
// - type one means error entry
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module brre_top
	import brre_pkg::*;
#(
	parameter logic [31:0] BUF_BASE  = 32'h0000_0000, // buffer start in shared memory
	parameter int          BUF_WORDS = BRRE_BUF_WORDS // buffer depth in words
)(
	input  wire logic        pclk,        // apb clock
	input  wire logic        presetn,     // async reset, active low
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb enable
	input  wire logic        pwrite,      // apb direction
	input  wire logic [7:0]  paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic [31:0]      prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error
	input  wire logic        bc_enabled,  // bus controller mode active
	output logic             mem_req,     // shared-memory read request
	output logic [31:0]      mem_addr,    // shared-memory byte address
	input  wire logic        mem_ack,     // memory answer valid
	input  wire logic [31:0] mem_rdata,   // memory answer data
	output logic             tx_valid,    // word for the protocol engine
	output logic [3:0]       tx_kind,     // monitor type of that word
	output logic [26:0]      tx_entry,    // entry field of that word
	input  wire logic        tx_done,     // engine sent the word
	input  wire logic        rsp_seen,    // outside rt answered
	output logic             half_irq,    // half-buffer transmitted pulse
	output logic             running      // replay active
);
	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		BRRE_S_IDLE  = 5'b00001,
		BRRE_S_FETCH = 5'b00010,
		BRRE_S_SEND  = 5'b00100,
		BRRE_S_WAIT  = 5'b01000,
		BRRE_S_NEXT  = 5'b10000
	} brre_state_t;

	localparam int AW = $clog2(BUF_WORDS); // word index width

	brre_state_t    state;       // sequencer state
	logic [31:0]    ctrl;        // control register
	logic [31:0]    entry_cnt;   // remaining entries
	logic [31:0]    half_cnt;    // half-buffer events
	logic [15:0]    swx_mask;    // status exception mask
	logic [15:0]    timeout_cyc; // response timeout in cycles
	logic [15:0]    wait_cnt;    // response wait counter
	logic [AW-1:0]  idx;         // word index in the ring
	logic [31:0]    cur_word;    // last fetched word
	logic           reject;      // start refused due to bc mode
	logic           timeouts;    // a response timed out
	logic           stop_nu;     // stopped on not-updated entry
	logic           rt_match;    // command targets the suppressed rt
	logic           is_err;      // decoded: error entry
	logic           d_start;     // decoded: start trigger
	logic           d_tx;        // decoded: transmit
	logic           d_rx;        // decoded: receive
	logic [15:0]    d_err;       // decoded: error field
	logic           wr;          // apb write access phase
	logic           rd;          // apb read access phase
	brre_tt_t       tt_mode;     // time-tag option
	logic           skip_word;   // word not put on the bus
	logic           last_word;   // index at end of ring
	logic           half_edge;   // index at end of a half
	logic           tx_sent;     // strobe already issued for this word

	assign wr        = psel & penable & pwrite & pready; // commits at the ready edge only
	assign rd        = psel & penable & ~pwrite & ~pready;
	assign tt_mode   = brre_tt_t'(ctrl[BRRE_CTRL_TT_LO +: 2]);
	assign last_word = (idx == AW'(BUF_WORDS - 1));
	assign half_edge = last_word | (idx == AW'(BUF_WORDS / 2 - 1));

	// ----------------------------------------------------------------
	// decode of the fetched word
	// ----------------------------------------------------------------
	brre_err_decode u_dec (
		.word      (cur_word),
		.is_error  (is_err),
		.start_trg (d_start),
		.tx_cmd    (d_tx),
		.rx_cmd    (d_rx),
		.err_field (d_err)
	);

	// command words of the suppressed rt still go out; their answer is awaited from the external rt
	assign rt_match = ctrl[BRRE_CTRL_RTDIS] & cur_word[31] & ~cur_word[29] & ~cur_word[28]
		& (cur_word[15:11] == ctrl[BRRE_CTRL_RTA_LO +: 5]);

	// error entries are never replayed; time tags obey the option
	always_comb begin
		skip_word = 1'b0;
		unique case (cur_word[31:28])
			BRRE_TYPE_ERROR: skip_word = 1'b1;
			BRRE_TYPE_TTLO:  skip_word = (tt_mode == BRRE_TT_OFF);
			BRRE_TYPE_TTHI:  skip_word = (tt_mode != BRRE_TT_FULL);
			// commands still go out; the suppressed rt's own status is left to the external rt
			default:         skip_word = ctrl[BRRE_CTRL_RTDIS] & (cur_word[31:28] == 4'hB || cur_word[31:28] == 4'hF) & (cur_word[15:11] == ctrl[BRRE_CTRL_RTA_LO +: 5]);
		endcase
	end

	// ----------------------------------------------------------------
	// apb slave: one wait state, pready is a registered pulse
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (rd) begin
				unique case (paddr)
					BRRE_REG_CTRL:    prdata <= ctrl;
					BRRE_REG_COUNT:   prdata <= entry_cnt;
					BRRE_REG_HALFCNT: prdata <= half_cnt;
					BRRE_REG_SWXMASK: prdata <= {16'h0000, swx_mask};
					BRRE_REG_STATUS:  prdata <= {28'h0000000, stop_nu, timeouts, reject, running};
					BRRE_REG_WORD:    prdata <= cur_word;
					BRRE_REG_ERRDEC:  prdata <= {5'h00, d_start, 8'h00, d_tx, d_rx, d_err};
					BRRE_REG_TIMEOUT: prdata <= {16'h0000, timeout_cyc};
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1; // unmapped address
					end
				endcase
			end else if (psel & penable & pwrite & ~pready) begin
				prdata <= 32'h0000_0000;
				pslverr <= ~(paddr inside {BRRE_REG_CTRL, BRRE_REG_COUNT, BRRE_REG_SWXMASK, BRRE_REG_TIMEOUT});
			end
		end
	end

	// ----------------------------------------------------------------
	// software-written configuration
	// ----------------------------------------------------------------
	// start bit is refused while bc mode is on; replay is the bus master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl        <= 32'h0000_0000;
			swx_mask    <= BRRE_SWX_RESET;
			timeout_cyc <= 16'(BRRE_TIMEOUT_CYC);
			reject      <= 1'b0;
		end else begin
			if (wr && paddr == BRRE_REG_CTRL) begin
				ctrl   <= {pwdata[31:1], pwdata[BRRE_CTRL_START] & ~bc_enabled};
				reject <= pwdata[BRRE_CTRL_START] & bc_enabled;
			end else if (state == BRRE_S_IDLE && running) begin
				ctrl[BRRE_CTRL_START] <= 1'b0; // replay ended, clear request
			end
			if (wr && paddr == BRRE_REG_SWXMASK)
				swx_mask <= pwdata[15:0];
			if (wr && paddr == BRRE_REG_TIMEOUT && pwdata[15:0] != 16'h0000)
				timeout_cyc <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// replay sequencer
	// ----------------------------------------------------------------
	// rt and monitor modes are independent and may run alongside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= BRRE_S_IDLE;
			running  <= 1'b0;
			idx      <= '0;
			cur_word <= 32'h0000_0000;
			wait_cnt <= 16'h0000;
			stop_nu  <= 1'b0;
			timeouts <= 1'b0;
		end else begin
			unique case (state)
				BRRE_S_IDLE: begin
					running <= 1'b0;
					if (ctrl[BRRE_CTRL_START] && !running && entry_cnt != 32'h0000_0000) begin
						state    <= BRRE_S_FETCH;
						running  <= 1'b1;
						idx      <= '0;
						stop_nu  <= 1'b0;
						timeouts <= 1'b0;
					end
				end
				BRRE_S_FETCH: begin
					if (mem_ack) begin
						cur_word <= mem_rdata;
						if (mem_rdata[31:28] == BRRE_TYPE_NOTUPD) begin
							state   <= BRRE_S_IDLE;
							stop_nu <= 1'b1;
						end else begin
							state <= BRRE_S_SEND;
						end
					end
				end
				BRRE_S_SEND: begin
					wait_cnt <= 16'h0000;
					if (skip_word)
						state <= BRRE_S_NEXT;
					else if (tx_done)
						state <= (cur_word[31:28] == 4'hB || cur_word[31:28] == 4'hF) ? BRRE_S_NEXT : BRRE_S_WAIT;
				end
				BRRE_S_WAIT: begin
					// external rt timing differs from the recording; wait for it
					wait_cnt <= wait_cnt + 16'h0001;
					if (rsp_seen || !rt_match) begin
						state <= BRRE_S_NEXT;
					end else if (wait_cnt >= timeout_cyc) begin
						state    <= BRRE_S_NEXT;
						timeouts <= 1'b1;
					end
				end
				BRRE_S_NEXT: begin
					idx   <= last_word ? '0 : idx + AW'(1);
					state <= (entry_cnt == 32'h0000_0001) ? BRRE_S_IDLE : BRRE_S_FETCH;
				end
				default: state <= BRRE_S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// entry and half-buffer counters
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_cnt <= 32'h0000_0000;
			half_cnt  <= 32'h0000_0000;
			half_irq  <= 1'b0;
		end else begin
			half_irq <= 1'b0;
			if (wr && paddr == BRRE_REG_COUNT && !running)
				entry_cnt <= pwdata; // only loaded while stopped
			else if (state == BRRE_S_NEXT)
				entry_cnt <= entry_cnt - 32'h0000_0001;
			if (state == BRRE_S_NEXT && half_edge) begin
				half_cnt <= half_cnt + 32'h0000_0001;
				half_irq <= ctrl[BRRE_CTRL_HALFIE];
			end
		end
	end

	// ----------------------------------------------------------------
	// memory and protocol engine outputs
	// ----------------------------------------------------------------
	// host refills the other half reads here never touch it early
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req  <= 1'b0;
			mem_addr <= 32'h0000_0000;
			tx_valid <= 1'b0;
			tx_kind  <= 4'h0;
			tx_entry <= 27'h0000000;
			tx_sent  <= 1'b0;
		end else begin
			tx_sent  <= (state == BRRE_S_SEND) & (tx_sent | tx_valid); // one strobe per word
			mem_req  <= (state == BRRE_S_FETCH) & ~mem_ack;
			mem_addr <= BUF_BASE + {{(30-AW){1'b0}}, idx, 2'b00};
			tx_valid <= (state == BRRE_S_SEND) & ~skip_word & ~tx_done & ~tx_valid & ~tx_sent;
			tx_kind  <= cur_word[31:28];
			tx_entry <= cur_word[26:0];
		end
	end

endmodule : brre_top
`default_nettype wire

/* verif/brre_properties.sv */
// brre_properties: port-level checks for brre_top, bound from the bench.
// assumes: one clock pclk, async active-low presetn.
`timescale 1ns/100ps
`default_nettype none
module brre_properties
	import brre_pkg::*;
#(
	parameter logic [31:0] BUF_BASE  = 32'h0000_0000, // ring start
	parameter int          BUF_WORDS = BRRE_BUF_WORDS // ring depth
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        bc_enabled,
	input wire logic        mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic        tx_valid,
	input wire logic [3:0]  tx_kind,
	input wire logic        half_irq,
	input wire logic        running
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [9:0] stall; // idle cycles inside a replay, saturating
	// a silent terminal must not freeze the replay for long
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stall <= 10'h000;
		else if (!running || mem_req || tx_valid)
			stall <= 10'h000;
		else if (stall != 10'h3FF)
			stall <= stall + 10'h001;
	end
	sequence s_first_access;
		psel && penable && !pready;
	endsequence
	sequence s_mem_wait;
		mem_req && !mem_ack;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	apb_wait_a: assert property (s_first_access |=> pready)
		else $error("ready not one cycle after access");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (s_first_access ##0 (paddr > 8'h1C) |=> pslverr)
		else $error("unmapped access not flagged");
	bc_reject_a: assert property (bc_enabled && !running |=> !running)
		else $error("replay started beside bus controller");
	mem_hold_a: assert property (s_mem_wait |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
	ring_addr_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00 && mem_addr >= BUF_BASE
		&& mem_addr < BUF_BASE + 4 * BUF_WORDS) else $error("fetch outside ring");
	tx_pulse_a: assert property (tx_valid |-> running ##1 !tx_valid)
		else $error("bad word strobe");
	tx_kind_a: assert property (tx_valid |-> tx_kind != BRRE_TYPE_NOTUPD && tx_kind != BRRE_TYPE_ERROR)
		else $error("error or empty entry sent");
	half_pulse_a: assert property (half_irq |=> !half_irq)
		else $error("half event longer than a cycle");
	stall_bound_a: assert property (stall < 10'd1000)
		else $error("replay stalled");
endmodule : brre_properties
`default_nettype wire

/* verif/brre_far_model.sv */
// brre_far_model: shared memory ring plus protocol engine and outside terminal.
// assumes: 16-word ring at address 0, same clock as brre_top.
`timescale 1ns/100ps
`default_nettype none
module brre_far_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata,
	input  wire logic        tx_valid,
	output logic             tx_done,
	output logic             rsp_seen,
	input  wire logic        mute
);
	logic [31:0] mem [0:15]; // recorded words, refilled by the bench
	logic [2:0]  wt;         // wait count, varies with address
	logic [3:0]  sh;         // strobe history for done and answer
	// recording of one terminal set, same protocol variant
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = {4'hA, 12'h000, 16'(i)};
		mem[2] = 32'h2000_0001;
		mem[3] = 32'h3000_0801;
		mem[5] = 32'h17FE_0012;
		mem[9] = 32'h8000_2C22;
		mem_ack = 1'b0;
		mem_rdata = 32'h0000_0000;
		tx_done = 1'b0;
		rsp_seen = 1'b0;
		wt = 3'h0;
		sh = 4'h0;
	end
	// memory answers after 0..3 waits; data off-ack keeps changing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wt <= 3'h0;
		end else if (mem_req && !mem_ack && wt == {1'b0, mem_addr[3:2]}) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[5:2]];
			wt <= 3'h0;
		end else begin
			if (mem_req && !mem_ack)
				wt <= wt + 3'h1;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
	// engine done, then outside terminal answers unless muted
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh <= 4'h0;
			tx_done <= 1'b0;
			rsp_seen <= 1'b0;
		end else begin
			sh <= {sh[2:0], tx_valid};
			tx_done <= sh[1];
			rsp_seen <= sh[3] & !mute;
		end
	end
endmodule : brre_far_model
`default_nettype wire

/* verif/brre_top_test.sv */
// brre_top_test: apb-driven replay tests for brre_top.
// assumes: brre_far_model on the memory and engine side.
`timescale 1ns/100ps
`default_nettype none
module brre_top_test;
	import brre_pkg::*;
	localparam int BW = 16; // short ring keeps the run brief
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, bc_enabled = 1'b0, mute = 1'b1, e;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, q;
	logic [31:0] prdata, mem_addr, mem_rdata;
	logic        pready, pslverr, mem_req, mem_ack, tx_valid, tx_done, rsp_seen, half_irq, running;
	logic [3:0]  tx_kind;
	logic [26:0] tx_entry;
	int          err_count = 0, checks = 0, n_tx = 0, n_half = 0;
	always #20 pclk = ~pclk;
	brre_top #(.BUF_WORDS(BW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bc_enabled(bc_enabled), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_kind(tx_kind),
		.tx_entry(tx_entry), .tx_done(tx_done), .rsp_seen(rsp_seen), .half_irq(half_irq),
		.running(running));
	brre_far_model far (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_done(tx_done),
		.rsp_seen(rsp_seen), .mute(mute));
	// count sent words and half-ring events
	always @(posedge pclk) begin
		if (tx_valid === 1'b1)
			n_tx++;
		if (half_irq === 1'b1)
			n_half++;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// one apb transfer; request held until ready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			err_count++;
			$display("MISMATCH %0t apb timeout", $time);
			summarize;
		end
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q & m, exp, "register read");
	endtask : rdc
	// a stuck replay ends the run
	task wait_idle;
		int i;
		repeat (4) @(posedge pclk);
		for (i = 0; i < 4000 && running !== 1'b0; i++)
			@(posedge pclk);
		if (i >= 4000) begin
			err_count++;
			$display("MISMATCH %0t replay hang", $time);
			summarize;
		end
	endtask : wait_idle
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(BRRE_REG_SWXMASK, 32'h0000_FFFF, 32'h0000_07FF);
		rdc(BRRE_REG_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_015E);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({31'h0, e}, 32'h1, "unmapped read");
		$display("test reset done");
		// ring wrap, skips, muted suppressed terminal
		apb(1'b1, BRRE_REG_TIMEOUT, 32'h0000_0014);
		apb(1'b1, BRRE_REG_COUNT, 32'h0000_0016);
		apb(1'b1, BRRE_REG_CTRL, 32'h0000_00BB);
		wait_idle;
		chk(32'(n_tx), 32'd16, "sent words");
		chk(32'(n_half), 32'd2, "half events");
		rdc(BRRE_REG_HALFCNT, 32'hFFFF_FFFF, 32'h0000_0002);
		rdc(BRRE_REG_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
		rdc(BRRE_REG_STATUS, 32'h0000_000F, 32'h0000_0004);
		rdc(BRRE_REG_ERRDEC, 32'hFFFF_FFFF, 32'h0402_8012);
		$display("test replay done");
		// idle half refilled with an empty entry
		apb(1'b1, BRRE_REG_CTRL, 32'h0000_0000);
		far.mem[6] = 32'h0000_0000;
		mute <= 1'b0;
		apb(1'b1, BRRE_REG_COUNT, 32'h0000_000A);
		apb(1'b1, BRRE_REG_CTRL, 32'h0000_0001);
		wait_idle;
		rdc(BRRE_REG_STATUS, 32'h0000_0009, 32'h0000_0008);
		$display("test empty entry done");
		// start refused beside bus controller
		apb(1'b1, BRRE_REG_CTRL, 32'h0000_0000);
		bc_enabled <= 1'b1;
		apb(1'b1, BRRE_REG_COUNT, 32'h0000_0003);
		apb(1'b1, BRRE_REG_CTRL, 32'h0000_0001);
		repeat (4) @(posedge pclk);
		chk({31'h0, running}, 32'h0, "running");
		rdc(BRRE_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
		bc_enabled <= 1'b0;
		$display("test bc reject done");
		summarize;
	end
endmodule : brre_top_test
bind brre_top brre_properties #(.BUF_BASE(BUF_BASE), .BUF_WORDS(BUF_WORDS)) u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .bc_enabled(bc_enabled), .mem_req(mem_req), .mem_addr(mem_addr),
	.mem_ack(mem_ack), .tx_valid(tx_valid), .tx_kind(tx_kind), .half_irq(half_irq), .running(running));
`default_nettype wire
